// File: flash_store_command_handler.sv
`timescale 1ns/10ps
`default_nettype none
module flash_store_command_handler (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // command requests
   input wire logic req_valid,
   output logic req_ready,
   input wire flash_store_pkg::req_t req,
   // responses
   output logic rsp_valid,
   input wire logic rsp_ready,
   output flash_store_pkg::rsp_t rsp,
   // replies arriving for this node
   input wire logic rsp_in_valid,
   input wire logic [7:0] rsp_in_src_ep,
   output logic explicit_frame,
   // flash erase port
   output logic flash_erase_valid,
   input wire logic flash_erase_ready,
   output logic [6:0] flash_erase_block,
   // interrupt
   output logic irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   ////////////////////////////////////////////////////////////////
   // state

   flash_store_pkg::state_t state;
   flash_store_pkg::state_t next_state;
   logic bcast;
   logic api_en;
   logic explicit_en;
   logic [3:0] mask;
   logic [3:0] status;
   logic [7:0] last_op;
   logic last_fail;
   logic [15:0] cmd_count;
   logic [15:0] drop_count;
   logic walk_done;

   ////////////////////////////////////////////////////////////////
   // request decode

   wire logic [7:0] op = req.hdr[flash_store_pkg::BYTE_OP];
   wire logic [15:0] blk = {req.hdr[flash_store_pkg::BYTE_BLK],
                            req.hdr[flash_store_pkg::BYTE_BLK+1]};
   wire logic [15:0] off = {req.hdr[flash_store_pkg::BYTE_OFF],
                            req.hdr[flash_store_pkg::BYTE_OFF+1]};
   wire logic [15:0] len = {req.hdr[flash_store_pkg::BYTE_LEN],
                            req.hdr[flash_store_pkg::BYTE_LEN+1]};

   wire logic take = req_valid && req_ready;
   wire logic addressed = (req.cluster == flash_store_pkg::CLUSTER_ID)
                          && (req.dst_ep == flash_store_pkg::ENDPOINT);
   wire logic accept = take && addressed;
   wire logic is_geo = op == flash_store_pkg::OP_GEOMETRY;
   wire logic is_erase = op == flash_store_pkg::OP_ERASE;
   wire logic erase_all = is_erase && (len == 16'h0000);
   // block past the count is refused
   wire logic blk_ok = blk < flash_store_pkg::BLOCK_COUNT;
   wire logic erase_ok = is_erase && (erase_all || blk_ok);
   wire logic fail = !(is_geo || erase_ok);
   wire logic start_erase = accept && erase_ok;

   ////////////////////////////////////////////////////////////////
   // response build

   wire logic [7:0] rsp_code = op | flash_store_pkg::RESP_FLAG;
   wire logic [7:0] rsp_result = fail ? flash_store_pkg::RESULT_FAIL
                                      : flash_store_pkg::RESULT_OK;
   // geometry in block and offset fields
   wire logic [15:0] rsp_blk = is_geo ? flash_store_pkg::BLOCK_COUNT : blk;
   wire logic [15:0] rsp_off = is_geo ? flash_store_pkg::BLOCK_SIZE : off;
   wire flash_store_pkg::hdr_t next_hdr = {rsp_code, rsp_result,
                                           rsp_blk, rsp_off, 16'h0000};

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rsp <= '0;
         bcast <= 1'b0;
      end else if (accept) begin
         rsp.dst_ep <= req.src_ep;
         rsp.hdr <= next_hdr;
         bcast <= req.broadcast;
      end
   end

   ////////////////////////////////////////////////////////////////
   // sequencing

   always_comb begin
      next_state = state;
      unique case (state)
         flash_store_pkg::ST_IDLE: begin
            if (accept) begin
               if (erase_ok) begin
                  next_state = flash_store_pkg::ST_ERASE;
               end else if (!req.broadcast) begin
                  next_state = flash_store_pkg::ST_RESP;
               end
            end
         end
         flash_store_pkg::ST_ERASE: begin
            if (walk_done) begin
               next_state = bcast ? flash_store_pkg::ST_IDLE
                                  : flash_store_pkg::ST_RESP;
            end
         end
         flash_store_pkg::ST_RESP: begin
            if (rsp_ready) begin
               next_state = flash_store_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = flash_store_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state <= flash_store_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // one command at a time; the erase walk holds off the next request
   assign req_ready = state == flash_store_pkg::ST_IDLE;
   assign rsp_valid = state == flash_store_pkg::ST_RESP;

   erase_walker u_walker (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .start(start_erase),
      .erase_all(erase_all),
      .block(blk[6:0]),
      .done(walk_done),
      .flash_erase_valid(flash_erase_valid),
      .flash_erase_ready(flash_erase_ready),
      .flash_erase_block(flash_erase_block)
   );

   ////////////////////////////////////////////////////////////////
   // replies arriving for this node

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         explicit_frame <= 1'b0;
      end else begin
         explicit_frame <= rsp_in_valid && api_en
                           && ((rsp_in_src_ep == flash_store_pkg::ENDPOINT) || explicit_en);
      end
   end

   ////////////////////////////////////////////////////////////////
   // apb slave

   wire logic setup = psel && !penable;
   wire logic access = psel && penable;
   wire logic hit_ctrl = paddr == flash_store_pkg::ADDR_CTRL;
   wire logic hit_status = paddr == flash_store_pkg::ADDR_STATUS;
   wire logic hit_mask = paddr == flash_store_pkg::ADDR_MASK;
   wire logic hit_info = paddr == flash_store_pkg::ADDR_INFO;
   wire logic hit_count = paddr == flash_store_pkg::ADDR_COUNT;
   wire logic mapped = hit_ctrl || hit_status || hit_mask || hit_info || hit_count;
   wire logic wr = access && pwrite && mapped;
   wire logic busy = state != flash_store_pkg::ST_IDLE;
   wire logic [31:0] rd_mux = hit_ctrl ? {30'h00000000, explicit_en, api_en}
                            : hit_status ? {28'h0000000, status}
                            : hit_mask ? {28'h0000000, mask}
                            : hit_info ? {22'h000000, busy, last_fail, last_op}
                            : hit_count ? {drop_count, cmd_count}
                            : 32'h00000000;
   // only bits shown to software are cleared, so later events stay
   wire logic [3:0] clr = (access && !pwrite && hit_status) ? prdata[3:0] : 4'h0;
   wire logic cmd_done = (accept && !erase_ok) || walk_done;
   wire logic [3:0] events = {explicit_frame, take && !addressed,
                              accept && fail, cmd_done};

   assign pready = 1'b1;

   // read data is taken in setup so the access phase needs no wait
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? 32'h00000000 : rd_mux;
         pslverr <= !mapped;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         {explicit_en, api_en} <= flash_store_pkg::CTRL_RESET;
         mask <= flash_store_pkg::MASK_RESET;
      end else if (wr && hit_ctrl) begin
         {explicit_en, api_en} <= pwdata[1:0];
      end else if (wr && hit_mask) begin
         mask <= pwdata[3:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         last_op <= 8'h00;
         last_fail <= 1'b0;
         cmd_count <= 16'h0000;
         drop_count <= 16'h0000;
      end else begin
         if (accept) begin
            last_op <= op;
            last_fail <= fail;
         end
         if (cmd_done) begin
            cmd_count <= cmd_count + 16'h0001;
         end
         if (take && !addressed) begin
            drop_count <= drop_count + 16'h0001;
         end
      end
   end

   event_irq #(
      .WIDTH(flash_store_pkg::EVT_W)
   ) u_irq (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .set(events),
      .clr(clr),
      .mask(mask),
      .status(status),
      .irq(irq)
   );

   ////////////////////////////////////////////////////////////////
   // checks

   sequence s_erase_cmd;
      start_erase && !req.broadcast;
   endsequence

   sequence s_walk_end;
      state == flash_store_pkg::ST_ERASE && walk_done && !bcast;
   endsequence

   AST_DROP_FOREIGN: assert property (take && !addressed |=>
      state == flash_store_pkg::ST_IDLE && !flash_erase_valid)
      else $error("foreign cluster or endpoint acted upon");
   AST_NO_BCAST_REPLY: assert property (accept && req.broadcast && !erase_ok |=> !rsp_valid)
      else $error("reply sent to broadcast");
   AST_NO_BCAST_ERASE_REPLY: assert property (state == flash_store_pkg::ST_ERASE && walk_done && bcast |=>
      !rsp_valid)
      else $error("reply sent to broadcast erase");
   AST_REPLY_CODE: assert property (accept && !erase_ok && !req.broadcast |=>
      rsp_valid && rsp.hdr[0] == ($past(op) | flash_store_pkg::RESP_FLAG)
      && rsp.dst_ep == $past(req.src_ep))
      else $error("reply code or endpoint wrong");
   AST_RESULT_BITS: assert property (rsp_valid |-> rsp.hdr[1][7:1] == 7'h00)
      else $error("reserved result bits set");
   // an unknown op 0x80 also answers 0x80, but with the failure bit set
   AST_GEOMETRY: assert property (rsp_valid && rsp.hdr[0] == 8'h80 && rsp.hdr[1] == 8'h00 |->
      {rsp.hdr[2], rsp.hdr[3]} == 16'h0077 && {rsp.hdr[4], rsp.hdr[5]} == 16'h0200
      && {rsp.hdr[6], rsp.hdr[7]} == 16'h0000)
      else $error("geometry reply fields wrong");
   AST_ERASE_START: assert property (s_erase_cmd |=> state == flash_store_pkg::ST_ERASE && flash_erase_valid)
      else $error("erase did not start");
   AST_ERASE_ACK: assert property (s_walk_end |=>
      rsp_valid && rsp.hdr[0] == 8'h81 && rsp.hdr[1] == 8'h00 && {rsp.hdr[6], rsp.hdr[7]} == 16'h0000)
      else $error("erase reply wrong");
   AST_BAD_NO_ERASE: assert property (accept && fail |=>
      state != flash_store_pkg::ST_ERASE && !flash_erase_valid && rsp.hdr[1] == 8'h01)
      else $error("failed command touched flash");
   AST_EXPLICIT: assert property (rsp_in_valid && api_en && rsp_in_src_ep == 8'hE6 |=> explicit_frame)
      else $error("explicit indicator missing");
   AST_API_OFF: assert property (!api_en |=> !explicit_frame)
      else $error("indicator with api mode off");

   ////////////////////////////////////////////////////////////////
   // handshake and status checks

   sequence s_reply_wait;
      rsp_valid && !rsp_ready;
   endsequence

   sequence s_erase_stall;
      flash_erase_valid && !flash_erase_ready;
   endsequence

   // a stalled reply must not shift under the consumer
   AST_RSP_HOLD: assert property (s_reply_wait |=> rsp_valid && $stable(rsp))
      else $error("reply changed while waiting");
   AST_ERASE_HOLD: assert property (s_erase_stall |=>
      flash_erase_valid && $stable(flash_erase_block))
      else $error("erase block changed while stalled");
   // flash is only ever touched from the erase state
   AST_IDLE_NO_ERASE: assert property (state == flash_store_pkg::ST_IDLE |-> !flash_erase_valid)
      else $error("flash busy while idle");
   AST_ECHO_BLOCK: assert property (accept && !req.broadcast && !erase_ok && !is_geo |=>
      rsp.hdr[2] == $past(req.hdr[2]) && rsp.hdr[3] == $past(req.hdr[3]))
      else $error("block field not echoed in order");
   AST_GEO_RESULT: assert property (accept && is_geo && !req.broadcast |=> rsp.hdr[1] == 8'h00)
      else $error("geometry reply flagged failure");
   AST_DROP_STATUS: assert property (take && !addressed |=> status[flash_store_pkg::EVT_DROP])
      else $error("dropped request not flagged");
   AST_FAIL_STATUS: assert property (accept && fail |=> status[flash_store_pkg::EVT_ERROR])
      else $error("failed command not flagged");
   AST_EXPLICIT_MODE: assert property (rsp_in_valid && api_en && explicit_en |=> explicit_frame)
      else $error("explicit mode indicator missing");
   AST_PLAIN_EP: assert property (rsp_in_valid && !explicit_en && rsp_in_src_ep != 8'hE6 |=> !explicit_frame)
      else $error("indicator for plain endpoint");
endmodule
`default_nettype wire

// File: flash_store_pkg.sv
`default_nettype none
package flash_store_pkg;
   // frame addressing
   localparam logic [15:0] CLUSTER_ID = 16'h0023;
   localparam logic [7:0] ENDPOINT = 8'hE6;
   // command and response codes
   localparam logic [7:0] OP_GEOMETRY = 8'h00;
   localparam logic [7:0] OP_ERASE = 8'h01;
   localparam logic [7:0] RESP_FLAG = 8'h80;
   localparam logic [7:0] RESULT_OK = 8'h00;
   localparam logic [7:0] RESULT_FAIL = 8'h01;
   // store geometry
   localparam logic [15:0] BLOCK_COUNT = 16'h0077;
   localparam logic [15:0] BLOCK_SIZE = 16'h0200;
   localparam logic [6:0] LAST_BLOCK = 7'h76;
   // byte positions in the payload header
   localparam int BYTE_OP = 0;
   localparam int BYTE_OPT = 1;
   localparam int BYTE_BLK = 2;
   localparam int BYTE_OFF = 4;
   localparam int BYTE_LEN = 6;
   // apb register offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_MASK = 8'h08;
   localparam logic [7:0] ADDR_INFO = 8'h0C;
   localparam logic [7:0] ADDR_COUNT = 8'h10;
   // reset values
   localparam logic [1:0] CTRL_RESET = 2'h1;
   localparam logic [3:0] MASK_RESET = 4'h0;
   // event bits
   localparam int EVT_W = 4;
   localparam int EVT_DONE = 0;
   localparam int EVT_ERROR = 1;
   localparam int EVT_DROP = 2;
   localparam int EVT_EXPLICIT = 3;
   // byte 0 first; multi-byte fields most significant byte first
   typedef logic [0:7][7:0] hdr_t;
   typedef struct packed {
      logic [15:0] cluster;
      logic [7:0] dst_ep;
      logic [7:0] src_ep;
      logic broadcast;
      hdr_t hdr;
   } req_t;
   typedef struct packed {
      logic [7:0] dst_ep;
      hdr_t hdr;
   } rsp_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ERASE = 2'b01,
      ST_RESP = 2'b10
   } state_t;
endpackage
`default_nettype wire

// File: event_irq.sv
`timescale 1ns/10ps
`default_nettype none
module event_irq #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // events and software side
   input wire logic [WIDTH-1:0] set,
   input wire logic [WIDTH-1:0] clr,
   input wire logic [WIDTH-1:0] mask,
   output logic [WIDTH-1:0] status,
   // interrupt
   output logic irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   // set after clear: an event in the clearing cycle survives
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         status <= '0;
      end else begin
         status <= (status & ~clr) | set;
      end
   end

   assign irq = |(status & mask);

   AST_SET_WINS: assert property ((set != '0) |=> ((status & $past(set)) == $past(set)))
      else $error("event lost in status");
   AST_IRQ_RAISE: assert property ((|(set & mask)) |=> irq)
      else $error("unmasked event did not raise irq");
endmodule
`default_nettype wire

// File: erase_walker.sv
`timescale 1ns/10ps
`default_nettype none
module erase_walker (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // request
   input wire logic start,
   input wire logic erase_all,
   input wire logic [6:0] block,
   output logic done,
   // flash erase port
   output logic flash_erase_valid,
   input wire logic flash_erase_ready,
   output logic [6:0] flash_erase_block
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   logic busy;
   logic [6:0] last;
   wire logic step = busy && flash_erase_ready;
   wire logic final_step = step && (flash_erase_block == last);

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         busy <= 1'b0;
         last <= 7'h00;
         flash_erase_block <= 7'h00;
         done <= 1'b0;
      end else begin
         done <= final_step;
         if (start) begin
            busy <= 1'b1;
            flash_erase_block <= erase_all ? 7'h00 : block;
            last <= erase_all ? flash_store_pkg::LAST_BLOCK : block;
         end else if (final_step) begin
            busy <= 1'b0;
         end else if (step) begin
            flash_erase_block <= flash_erase_block + 7'h01;
         end
      end
   end

   assign flash_erase_valid = busy;

   AST_BLOCK_RANGE: assert property (flash_erase_valid |-> flash_erase_block <= flash_store_pkg::LAST_BLOCK)
      else $error("erase beyond last block");
   AST_ALL_FROM_ZERO: assert property (start && erase_all |=>
      flash_erase_valid && flash_erase_block == 7'h00 && last == flash_store_pkg::LAST_BLOCK)
      else $error("erase all did not start at block zero");
   AST_WALK_STEP: assert property (step && !final_step |=>
      flash_erase_block == $past(flash_erase_block) + 7'h01)
      else $error("erase walk skipped a block");
endmodule
`default_nettype wire

// File: flash_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // erase port
   input wire logic erase_valid,
   input wire logic [6:0] erase_block,
   output logic erase_ready,
   // test control and log
   input wire logic slow,
   output logic [118:0] erased,
   output logic [6:0] last_block,
   output int erase_cnt
);
   logic [7:0] lfsr;
   // slow mode stalls on a pseudo-random pattern
   assign erase_ready = !slow || lfsr[0];
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         lfsr <= 8'h5A;
         erased <= '0;
         last_block <= 7'h00;
         erase_cnt <= 0;
      end else begin
         lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         if (erase_valid && erase_ready) begin
            erased[erase_block] <= 1'b1;
            last_block <= erase_block;
            erase_cnt <= erase_cnt + 1;
         end
      end
   end
endmodule
`default_nettype wire

// File: tb_flash_store_command_handler.sv
`timescale 1ns/10ps
`default_nettype none
module tb_flash_store_command_handler;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic req_valid = 1'b0;
   logic req_ready;
   flash_store_pkg::req_t req = '0;
   logic rsp_valid;
   logic rsp_ready = 1'b0;
   flash_store_pkg::rsp_t rsp;
   logic rsp_in_valid = 1'b0;
   logic [7:0] rsp_in_src_ep = 8'h00;
   logic explicit_frame;
   logic erase_valid;
   logic erase_ready;
   logic [6:0] erase_block;
   logic irq;
   logic slow = 1'b0;
   logic [118:0] erased;
   logic [6:0] last_block;
   int erase_cnt;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   int seed = 6;
   int cnt0;
   logic [31:0] q;
   logic e;
   logic seen;
   logic [15:0] blk;
   logic [7:0] ep = 8'hE6;
   flash_store_pkg::rsp_t got;
   logic [7:0] ra [4] = '{8'h00, 8'h08, 8'h04, 8'h14};
   logic [31:0] rx [4] = '{32'h1, 32'h0, 32'h0, 32'h0};
   logic re [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
   logic [1:0] xc [5] = '{2'h1, 2'h1, 2'h3, 2'h0, 2'h2};
   logic [7:0] xs [5] = '{8'hE6, 8'h10, 8'h10, 8'hE6, 8'h10};
   logic xe [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
   logic [7:0] bo [4] = '{8'h01, 8'h01, 8'h05, 8'h7F};
   logic [15:0] bb [4] = '{16'h0077, 16'h0100, 16'h0003, 16'h0000};

   always #12.5 sys_clk = ~sys_clk;

   flash_store_command_handler dut (
      .sys_clk(sys_clk), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req_valid(req_valid), .req_ready(req_ready), .req(req),
      .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp),
      .rsp_in_valid(rsp_in_valid), .rsp_in_src_ep(rsp_in_src_ep), .explicit_frame(explicit_frame),
      .flash_erase_valid(erase_valid), .flash_erase_ready(erase_ready),
      .flash_erase_block(erase_block), .irq(irq)
   );

   flash_model fm (
      .sys_clk(sys_clk), .reset_n(reset_n), .erase_valid(erase_valid), .erase_block(erase_block),
      .erase_ready(erase_ready), .slow(slow), .erased(erased), .last_block(last_block),
      .erase_cnt(erase_cnt)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chkr(input logic [71:0] g, input logic [71:0] x);
      checks++;
      if (g !== x) begin
         error_cnt++;
         $display("ERROR t=%0t got %h exp %h", $time, g, x);
      end
   endtask

   task automatic chkw(input logic [31:0] g, input logic [31:0] x);
      chkr({40'h0, g}, {40'h0, x});
   endtask

   task automatic chkb(input logic g, input logic x);
      chkr({71'h0, g}, {71'h0, x});
   endtask

   // reply fields most significant byte first
   function automatic flash_store_pkg::rsp_t exp_rsp(input logic [7:0] op, input logic [7:0] res,
                                                      input logic [15:0] b, input logic [15:0] off);
      exp_rsp.dst_ep = ep;
      exp_rsp.hdr = {op | 8'h80, res, b, off, 16'h0000};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // options, offset zero, no data bytes
   task automatic send(input logic [15:0] cl, input logic [7:0] dep, input logic bc,
                       input logic [7:0] op, input logic [15:0] b, input logic [15:0] len);
      int n;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req <= '{cluster: cl, dst_ep: dep, src_ep: ep, broadcast: bc, hdr: {op, 8'h00, b, 16'h0, len}};
      do @(posedge sys_clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      seen = 1'b0;
      for (n = 0; n < 600 && !seen; n++) begin
         @(posedge sys_clk);
         if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
            got = rsp;
            seen = 1'b1;
         end
         rsp_ready <= (($random(seed) & 3) != 0);
      end
   endtask

   task automatic pulse_in(input logic [7:0] s);
      @(posedge sys_clk);
      rsp_in_valid <= 1'b1;
      rsp_in_src_ep <= s;
      @(posedge sys_clk);
      rsp_in_valid <= 1'b0;
      @(posedge sys_clk);
   endtask

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      foreach (ra[i]) begin
         apb(1'b0, ra[i], 32'h0);
         chkb(e, re[i]);
         chkw(q, rx[i]);
      end
      ep = 8'($random(seed));
      send(16'h0023, 8'hE6, 1'b0, 8'h00, 16'h0000, 16'h0000);
      chkb(seen, 1'b1);
      chkr(got, exp_rsp(8'h00, 8'h00, 16'h0077, 16'h0200));
      chkb(irq, 1'b0);
      apb(1'b1, 8'h08, 32'h1);
      @(posedge sys_clk);
      chkb(irq, 1'b1);
      apb(1'b0, 8'h04, 32'h0);
      chkw(q, 32'h1);
      @(posedge sys_clk);
      chkb(irq, 1'b0);
      foreach (xc[i]) begin
         apb(1'b1, 8'h00, {30'h0, xc[i]});
         pulse_in(xs[i]);
         chkb(explicit_frame, xe[i]);
      end
      slow <= 1'b1;
      send(16'h0023, 8'hE6, 1'b0, 8'h01, 16'h0055, 16'h0000);
      chkr(got, exp_rsp(8'h01, 8'h00, 16'h0055, 16'h0000));
      chkw(32'(erase_cnt), 32'd119);
      chkb(&erased, 1'b1);
      cnt0 = erase_cnt;
      foreach (bo[i]) begin
         send(16'h0023, 8'hE6, 1'b0, bo[i], bb[i], 16'h0200);
         chkr(got, exp_rsp(bo[i], 8'h01, bb[i], 16'h0000));
      end
      chkw(32'(erase_cnt), 32'(cnt0));
      for (int i = 0; i < 6; i++) begin
         blk = (i == 0) ? 16'h0000 : (i == 1) ? 16'h0076 : 16'(unsigned'($random(seed)) % 119);
         ep = 8'($random(seed));
         slow <= i[0];
         cnt0 = erase_cnt;
         send(16'h0023, 8'hE6, 1'b0, 8'h01, blk, 16'h0200);
         chkr(got, exp_rsp(8'h01, 8'h00, blk, 16'h0000));
         chkw(32'(erase_cnt - cnt0), 32'd1);
         chkw({25'h0, last_block}, {16'h0, blk});
      end
      apb(1'b0, 8'h04, 32'h0);
      send(16'h0024, 8'hE6, 1'b0, 8'h00, 16'h0000, 16'h0000);
      chkb(seen, 1'b0);
      send(16'h0023, 8'hE7, 1'b0, 8'h00, 16'h0000, 16'h0000);
      chkb(seen, 1'b0);
      apb(1'b0, 8'h04, 32'h0);
      chkw(q & 32'h4, 32'h4);
      send(16'h0023, 8'hE6, 1'b1, 8'h00, 16'h0000, 16'h0000);
      chkb(seen, 1'b0);
      // broadcast erase still walks the flash but stays silent
      cnt0 = erase_cnt;
      send(16'h0023, 8'hE6, 1'b1, 8'h01, 16'h0005, 16'h0200);
      chkb(seen, 1'b0);
      chkw(32'(erase_cnt - cnt0), 32'd1);
      chkw({25'h0, last_block}, 32'h00000005);
      // fourteen finished commands, two dropped requests
      apb(1'b0, 8'h10, 32'h0);
      chkw(q, 32'h0002000E);
      apb(1'b0, 8'h0C, 32'h0);
      chkw(q, 32'h00000001);
      give_verdict;
   end
endmodule
`default_nettype wire
